// *** tde_engine.v ***
// two-channel dual-address transfer engine with register port and bus master
//
// Contract
// - low address bits ignored on the bus by size; register reads return written bits, except that a prohibited size code keeps the old size.
// - incrementing destination advances by transfer size; fixed destination never moves.
// - destination address advances only after an error-free write.
// - count decrements when a source read completes properly.
// - any write to a channel clear register clears its status bits.
// - highest-priority requester gets one unit (transfer or whole burst).
// - fixed mode always prefers channel 0.
// - round robin demotes the channel that finished a unit.
// - round robin starts with channel 0 highest after reset.
// - each transfer reads source into a holding register, then writes destination.
// - cycle steal drops bus request after every unit and re-requests.
// - cycle steal lets a higher channel in after the current unit.
// - burst keeps bus request until the whole count completes; the code also ends it early when the channel is masked or a bus error occurs.
// - burst blocks higher channels until the burst finishes.
// - size field 00 byte, 01 half-word, 10 word, 11 prohibited.
// - ownership bit 0 burst, 1 cycle steal; resets to burst.
// - destination type bit 0 fixed, 1 incrementing; resets fixed.
// - masked channels do not transfer; channels reset masked.
`timescale 1ns/10ps
`default_nettype none
`include "tde_map.vh"
module tde_engine #(
  parameter AW = 8
) (
  input wire sys_clk,
  input wire rst_n,
  input wire [AW-1:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  input wire [1:0] dreq,
  output wire bus_req,
  input wire bus_gnt,
  output reg bus_valid,
  output reg bus_write,
  output reg [31:0] bus_addr,
  output reg [1:0] bus_size,
  output reg [31:0] bus_wdata,
  input wire [31:0] bus_rdata,
  input wire bus_done,
  input wire bus_err,
  output wire [1:0] irq_pending
);
  localparam ST_IDLE = 2'h0;
  localparam ST_READ = 2'h1;
  localparam ST_WRITE = 2'h2;
  localparam ST_GAP = 2'h3;

  // masks the low bits according to size; register value itself is kept whole
  function [31:0] align;
    input [31:0] a;
    input [1:0] sz;
    begin
      if (sz == `TDE_SIZE_WORD) begin
        align = {a[31:2], 2'h0};
      end else if (sz == `TDE_SIZE_HALF) begin
        align = {a[31:1], 1'h0};
      end else begin
        align = a;
      end
    end
  endfunction

  function [31:0] step;
    input [1:0] sz;
    begin
      if (sz == `TDE_SIZE_WORD) begin
        step = 32'h00000004;
      end else if (sz == `TDE_SIZE_HALF) begin
        step = 32'h00000002;
      end else begin
        step = 32'h00000001;
      end
    end
  endfunction

  // three-flop sync of peripheral request lines
  // a level is taken only once the second and third stages agree
  reg [1:0] dreq_s1_q, dreq_s2_q, dreq_s3_q, dreq_q;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dreq_s1_q <= 2'h0;
      dreq_s2_q <= 2'h0;
      dreq_s3_q <= 2'h0;
      dreq_q <= 2'h0;
    end else begin
      dreq_s1_q <= dreq;
      dreq_s2_q <= dreq_s1_q;
      dreq_s3_q <= dreq_s2_q;
      if (dreq_s2_q == dreq_s3_q) begin
        dreq_q <= dreq_s3_q;
      end
    end
  end

  reg [1:0] mask_q;
  reg [6:0] mode_q [0:1];
  reg [31:0] src_q [0:1];
  reg [31:0] dst_q [0:1];
  reg [`TDE_CNT_W-1:0] cnt_q [0:1];
  reg [1:0] irq_q, end_q, cyc_q;
  reg rr_q, gmode_q;
  reg [1:0] st_q;
  reg cur_q, burst_q;
  reg [31:0] hold_q;

  wire [2:0] ch_sel = reg_addr[7:5];
  // offset within a channel block, widened to the width of the map constants
  wire [7:0] ch_off = {3'h0, reg_addr[4:0]};
  wire wch = reg_addr[5];
  wire in_ch = (ch_sel < 3'h2);

  // a channel may start a unit when unmasked, with transfers left, no abnormal end
  // waiting to be cleared, and either auto request or a synced peripheral request
  function chan_ready;
    input msk;
    input [`TDE_CNT_W-1:0] cnt;
    input abn;
    input auto_req;
    input ext_req;
    begin
      chan_ready = !msk && (cnt != {`TDE_CNT_W{1'b0}}) && !abn && (auto_req || ext_req);
    end
  endfunction

  // an abnormal end parks the channel until its status is cleared, so a bad
  // address is not retried behind software's back
  wire [1:0] ready;
  assign ready[0] = chan_ready(mask_q[0], cnt_q[0], end_q[0],
    mode_q[0][`TDE_MODE_AUTO], dreq_q[0]);
  assign ready[1] = chan_ready(mask_q[1], cnt_q[1], end_q[1],
    mode_q[1][`TDE_MODE_AUTO], dreq_q[1]);

  // arbitration reads gmode only in idle, so changes land between units
  // in round robin, rr_q names the channel preferred when both are ready
  wire pick = (ready == 2'h3) ? (gmode_q ? rr_q : 1'b0) : ready[1];

  wire [1:0] cur_sz = mode_q[cur_q][`TDE_MODE_SIZE_HI:`TDE_MODE_SIZE_LO];
  wire last = (cnt_q[cur_q] == 0);
  // cycle steal releases request in the gap; burst holds it throughout
  assign bus_req = (st_q == ST_READ) || (st_q == ST_WRITE) || (st_q == ST_GAP && burst_q);
  assign irq_pending = irq_q;

  wire wr_clr0 = reg_wr && in_ch && !wch && (ch_off == `TDE_OFF_CLR);
  wire wr_clr1 = reg_wr && in_ch && wch && (ch_off == `TDE_OFF_CLR);

  integer i;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= 2'h3;
      for (i = 0; i < 2; i = i + 1) begin
        mode_q[i] <= 7'h00;
        src_q[i] <= `TDE_RESET_WORD;
        dst_q[i] <= `TDE_RESET_WORD;
        cnt_q[i] <= {`TDE_CNT_W{1'b0}};
      end
      irq_q <= 2'h0;
      end_q <= 2'h0;
      cyc_q <= 2'h0;
      rr_q <= 1'b0;
      gmode_q <= 1'b0;
      st_q <= ST_IDLE;
      cur_q <= 1'b0;
      burst_q <= 1'b0;
      hold_q <= 32'h00000000;
      bus_valid <= 1'b0;
      bus_write <= 1'b0;
      bus_addr <= 32'h00000000;
      bus_size <= 2'h0;
      bus_wdata <= 32'h00000000;
      reg_rdata <= 32'h00000000;
    end else begin
      // register writes; same offsets in each channel block
      if (reg_wr && in_ch) begin
        case (ch_off)
          `TDE_OFF_MASK: mask_q[wch] <= reg_wdata[0];
          `TDE_OFF_MODE: begin
            // a prohibited size code keeps the old size, so the bus never carries it
            if (reg_wdata[`TDE_MODE_SIZE_HI:`TDE_MODE_SIZE_LO] == 2'h3) begin
              mode_q[wch] <= {reg_wdata[6:3], mode_q[wch][2:1], reg_wdata[0]};
            end else begin
              mode_q[wch] <= reg_wdata[6:0];
            end
          end
          `TDE_OFF_SRC: src_q[wch] <= reg_wdata;
          `TDE_OFF_DST: dst_q[wch] <= reg_wdata;
          `TDE_OFF_CNT: cnt_q[wch] <= reg_wdata[`TDE_CNT_W-1:0];
          default: ;
        endcase
      end
      if (reg_wr && reg_addr == `TDE_OFF_GMODE) begin
        gmode_q <= reg_wdata[0];
      end
      // clear first so hardware set below wins in the same cycle
      if (wr_clr0) begin
        irq_q[0] <= 1'b0;
        end_q[0] <= 1'b0;
        cyc_q[0] <= 1'b0;
      end
      if (wr_clr1) begin
        irq_q[1] <= 1'b0;
        end_q[1] <= 1'b0;
        cyc_q[1] <= 1'b0;
      end
      // read port
      // data stand for one cycle only; idle cycles read as zero
      reg_rdata <= 32'h00000000;
      if (reg_rd) begin
        if (in_ch) begin
          case (ch_off)
            `TDE_OFF_MASK: reg_rdata <= {31'h0, mask_q[wch]};
            `TDE_OFF_MODE: reg_rdata <= {25'h0, mode_q[wch]};
            `TDE_OFF_SRC: reg_rdata <= src_q[wch];
            `TDE_OFF_DST: reg_rdata <= dst_q[wch];
            `TDE_OFF_CNT: reg_rdata <= {15'h0, cnt_q[wch]};
            default: reg_rdata <= 32'h00000000;
          endcase
        end else if (reg_addr == `TDE_OFF_GMODE) begin
          reg_rdata <= {31'h0, gmode_q};
        end else if (reg_addr == `TDE_OFF_STAT) begin
          reg_rdata <= {14'h0, cyc_q, 6'h0, end_q, 6'h0, irq_q};
        end
      end
      // transfer sequencer
      case (st_q)
        ST_IDLE: begin
          // ownership mode is frozen per unit, so a mode write mid-unit waits
          if (ready != 2'h0) begin
            cur_q <= pick;
            burst_q <= !mode_q[pick][`TDE_MODE_OWN];
            st_q <= ST_READ;
          end
        end
        ST_READ: begin
          if (bus_gnt && !bus_valid) begin
            bus_valid <= 1'b1;
            bus_write <= 1'b0;
            bus_size <= cur_sz;
            bus_addr <= align(src_q[cur_q], cur_sz);
          end
          if (bus_valid && bus_done) begin
            bus_valid <= 1'b0;
            // a failed read ends the channel with its count untouched
            if (bus_err) begin
              irq_q[cur_q] <= 1'b1;
              end_q[cur_q] <= 1'b1;
              cyc_q[cur_q] <= 1'b0;
              st_q <= ST_IDLE;
            end else begin
              hold_q <= bus_rdata;
              cnt_q[cur_q] <= cnt_q[cur_q] - 1'b1;
              if (mode_q[cur_q][`TDE_MODE_SRC_INC]) begin
                src_q[cur_q] <= src_q[cur_q] + step(cur_sz);
              end
              st_q <= ST_WRITE;
            end
          end
        end
        ST_WRITE: begin
          if (!bus_valid && !bus_done) begin
            bus_valid <= 1'b1;
            bus_write <= 1'b1;
            bus_addr <= align(dst_q[cur_q], cur_sz);
            bus_wdata <= hold_q;
          end
          if (bus_valid && bus_done) begin
            bus_valid <= 1'b0;
            // a failed write leaves the destination address where it was
            if (bus_err) begin
              irq_q[cur_q] <= 1'b1;
              end_q[cur_q] <= 1'b1;
              cyc_q[cur_q] <= 1'b1;
              st_q <= ST_IDLE;
            end else begin
              if (mode_q[cur_q][`TDE_MODE_DEST_INC]) begin
                dst_q[cur_q] <= dst_q[cur_q] + step(cur_sz);
              end
              if (last) begin
                irq_q[cur_q] <= 1'b1;
                end_q[cur_q] <= 1'b0;
              end
              st_q <= ST_GAP;
            end
          end
        end
        default: begin
          // burst keeps the channel unless done or masked; else re-arbitrate
          if (burst_q && !last && !mask_q[cur_q]) begin
            st_q <= ST_READ;
          end else begin
            rr_q <= ~cur_q;
            st_q <= ST_IDLE;
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// *** tde_map.vh ***
// register map and field constants of the two-channel transfer engine
`ifndef TDE_MAP_VH
`define TDE_MAP_VH
`define TDE_OFF_MASK 8'h00
`define TDE_OFF_MODE 8'h04
`define TDE_OFF_SRC 8'h08
`define TDE_OFF_DST 8'h0c
`define TDE_OFF_CNT 8'h10
`define TDE_OFF_CLR 8'h14
`define TDE_CH_STRIDE 8'h20
`define TDE_OFF_GMODE 8'h40
`define TDE_OFF_STAT 8'h44
`define TDE_MODE_SIZE_LO 1
`define TDE_MODE_SIZE_HI 2
`define TDE_MODE_DEST_INC 4
`define TDE_MODE_SRC_INC 3
`define TDE_MODE_OWN 5
`define TDE_MODE_AUTO 0
`define TDE_SIZE_BYTE 2'h0
`define TDE_SIZE_HALF 2'h1
`define TDE_SIZE_WORD 2'h2
`define TDE_CNT_W 17
`define TDE_RESET_WORD 32'h00000000
`define TDE_STAT_REQ 0
`define TDE_STAT_END 8
`define TDE_STAT_CYC 16
`endif

// *** tde_bus_model.sv ***
// bus slave model: grants the bus, answers each access, errors on top nibble f
`timescale 1ns/10ps
`default_nettype none
module tde_bus_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic hold,
  input wire logic bus_req,
  input wire logic bus_valid,
  input wire logic [31:0] bus_addr,
  output logic bus_gnt,
  output logic bus_done,
  output logic bus_err,
  output logic [31:0] bus_rdata
);
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      {bus_gnt, bus_done, bus_err, bus_rdata} <= '0;
    end else begin
      bus_gnt <= bus_req && !hold;
      bus_done <= bus_valid && !bus_done;
      bus_err <= bus_valid && !bus_done && bus_addr[31:28] == 4'hf;
      // a released data bus must not look like a stale valid word
      bus_rdata <= (bus_valid && !bus_done) ? ~bus_addr : ~bus_rdata;
    end
  end
endmodule
`default_nettype wire

// *** tde_engine_asserts.sv ***
// checker on the engine's register port and bus master
`timescale 1ns/10ps
`default_nettype none
module tde_engine_asserts #(
  parameter AW = 8
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [AW-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic bus_valid,
  input wire logic bus_write,
  input wire logic [31:0] bus_addr,
  input wire logic [1:0] bus_size,
  input wire logic [31:0] bus_wdata,
  input wire logic [31:0] bus_rdata,
  input wire logic bus_done,
  input wire logic bus_err,
  input wire logic [1:0] irq_pending
);
  logic [31:0] held_q;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      held_q <= '0;
    end else if (bus_valid && !bus_write && bus_done) begin
      held_q <= bus_rdata;
    end
  end
  sequence rd_end(e); bus_valid && !bus_write && bus_done && bus_err == e; endsequence
  sequence wr_next; !bus_valid ##1 bus_valid && bus_write; endsequence
  AST_RD_WR: assert property (rd_end(1'b0) |=> wr_next)
    else $error("write does not follow a good read");
  AST_ERR_NO_WR: assert property (rd_end(1'b1) |=> !(bus_valid && bus_write) [*2])
    else $error("write after failed read");
  AST_WDATA: assert property (bus_valid && bus_write |-> bus_wdata == held_q)
    else $error("write data differs from read data");
  AST_HOLD: assert property (bus_valid && !bus_done |=> bus_valid && $stable(bus_addr))
    else $error("access dropped before done");
  AST_SIZE: assert property (bus_valid |-> bus_size != 2'h3)
    else $error("prohibited size on bus");
  AST_ALIGN: assert property (bus_valid |-> (bus_addr[1:0] & {bus_size[1], |bus_size}) == 2'h0)
    else $error("low address bits not ignored");
  AST_CLR: assert property (reg_wr && reg_addr == 8'h14 && !bus_done && !$past(bus_done)
    |=> !irq_pending[0])
    else $error("clear left request pending");
  AST_RDATA: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data outside read cycle");
endmodule
bind tde_engine tde_engine_asserts #(.AW(AW)) i_tde_engine_asserts (.sys_clk, .rst_n,
  .reg_addr, .reg_wr, .reg_rd, .reg_rdata, .bus_valid, .bus_write, .bus_addr, .bus_size,
  .bus_wdata, .bus_rdata, .bus_done, .bus_err, .irq_pending);
`default_nettype wire

// *** tde_engine_tb.sv ***
// self-checking bench of the two-channel transfer engine
`timescale 1ns/10ps
`default_nettype none
module tde_engine_tb;
  logic sys_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, hold = 0;
  logic [7:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0, reg_rdata, bus_addr, bus_wdata, bus_rdata, seq;
  logic [1:0] dreq = '0, bus_size, irq_pending;
  logic bus_req, bus_gnt, bus_valid, bus_write, bus_done, bus_err;
  int miscompares = 0, n_tests = 0, drops = 0;
  logic [31:0] wq[$], rq[$];
  always #2.5 sys_clk = ~sys_clk;
  tde_engine i_tde_engine (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .dreq, .bus_req, .bus_gnt, .bus_valid, .bus_write, .bus_addr, .bus_size,
    .bus_wdata, .bus_rdata, .bus_done, .bus_err, .irq_pending);
  tde_bus_model i_tde_bus_model (.sys_clk, .rst_n, .hold, .bus_req, .bus_valid, .bus_addr,
    .bus_gnt, .bus_done, .bus_err, .bus_rdata);
  always @(posedge sys_clk) begin
    if (bus_valid && bus_done && bus_write) wq.push_back(bus_addr);
    if (bus_valid && bus_done && !bus_write) rq.push_back(bus_addr);
    if (rst_n && $fell(bus_req)) drops++;
  end
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 0;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    @(posedge sys_clk);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 0;
    #1 chk($sformatf("reg %h", a), e, reg_rdata);
  endtask
  // count goes last so the channel only turns ready once fully set up
  task automatic setup(logic [7:0] b, logic [31:0] m, s, d, c);
    wr(b + 8'h04, m);
    wr(b + 8'h08, s);
    wr(b + 8'h0c, d);
    wr(b + 8'h10, c);
  endtask
  task automatic wait_irq(int ch);
    repeat (300) if (irq_pending[ch] !== 1'b1) @(posedge sys_clk);
    // let the request drop after the last unit be counted before any check
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic end_of_test();
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge sys_clk);
    rst_n <= 1;
    rd(8'h20, 32'h1);
    rd(8'h24, 32'h0);
    wr(8'h24, 32'h07);
    rd(8'h24, 32'h01);
    wr(8'h38, 32'hffffffff);
    rd(8'h38, 32'h0);
    wr(8'h2c, 32'h12345677);
    rd(8'h2c, 32'h12345677);
    setup(8'h00, 32'h15, 32'h200, 32'h100, 32'h3);
    wr(8'h00, 32'h0);
    wait_irq(0);
    chk("writes", 32'h3, 32'(wq.size()));
    foreach (wq[i]) chk("wr addr", 32'h100 + 32'(4 * i), wq[i]);
    rd(8'h10, 32'h0);
    rd(8'h0c, 32'h10c);
    rd(8'h44, 32'h1);
    chk("burst drops", 32'h1, 32'(drops));
    wr(8'h14, 32'h0);
    rd(8'h44, 32'h0);
    wq.delete();
    drops = 0;
    setup(8'h20, 32'h23, 32'h600, 32'h302, 32'h2);
    wr(8'h20, 32'h0);
    wait_irq(1);
    chk("steal drops", 32'h2, 32'(drops));
    chk("steal writes", 32'h2, 32'(wq.size()));
    foreach (wq[i]) chk("fixed addr", 32'h302, wq[i]);
    rd(8'h2c, 32'h302);
    wr(8'h34, 32'h0);
    setup(8'h00, 32'h15, 32'h200, 32'hf0000000, 32'h2);
    wait_irq(0);
    rd(8'h0c, 32'hf0000000);
    rd(8'h10, 32'h1);
    rd(8'h44, 32'h10101);
    wr(8'h10, 32'h0);
    wr(8'h14, 32'h0);
    setup(8'h20, 32'h21, 32'hf0000000, 32'h300, 32'h1);
    wait_irq(1);
    rd(8'h30, 32'h1);
    rd(8'h44, 32'h202);
    wr(8'h30, 32'h0);
    wr(8'h34, 32'h0);
    for (int g = 0; g < 2; g++) begin
      wr(8'h40, 32'(g));
      hold <= 1;
      setup(8'h00, 32'h21, 32'h400, 32'h700, 32'h2);
      setup(8'h20, 32'h21, 32'h500, 32'h710, 32'h2);
      rq.delete();
      hold <= 0;
      wait_irq(1);
      wait_irq(0);
      seq = '0;
      foreach (rq[i]) seq = {seq[27:0], rq[i][11:8]};
      chk("order", g ? 32'h4545 : 32'h4455, seq);
      wr(8'h14, 32'h0);
      wr(8'h34, 32'h0);
    end
    setup(8'h20, 32'h20, 32'h600, 32'h304, 32'h1);
    rd(8'h30, 32'h1);
    dreq <= 2'h2;
    wait_irq(1);
    rd(8'h30, 32'h0);
    chk("req write", 32'h304, wq[$]);
    dreq <= 2'h0;
    end_of_test();
  end
  initial begin
    #30000;
    miscompares++;
    end_of_test();
  end
endmodule
`default_nettype wire
